// ---- pld_cells_map.vh ----
// Constants shared by the output macrocell array and its product terms
`ifndef PLD_CELLS_MAP_VH
`define PLD_CELLS_MAP_VH

// ======================================================================
// Array dimensions
// ======================================================================
`define PLD_NUM_CELLS       10
`define PLD_NUM_DEDICATED   10
`define PLD_TERMS_PER_CELL  8
`define PLD_NUM_DATA_TERMS  4
`define PLD_NUM_SIGNALS     30
`define PLD_NUM_LITERALS    60

// ======================================================================
// Term positions inside one cell's group of product terms
// ======================================================================
`define PLD_TERM_DATA_LO    0
`define PLD_TERM_DATA_HI    3
`define PLD_TERM_CLOCK      4
`define PLD_TERM_RESET      5
`define PLD_TERM_PRESET     6
`define PLD_TERM_ENABLE     7

// ======================================================================
// Signal vector layout: dedicated inputs, I/O pins, cell feedback
// ======================================================================
`define PLD_SIG_DED_LO      0
`define PLD_SIG_IO_LO       10
`define PLD_SIG_FB_LO       20

// ======================================================================
// Reset values
// ======================================================================
`define PLD_STATE_RESET     10'h000
`define PLD_PIN_RESET       10'h3ff
`define PLD_ENABLE_RESET    10'h000
`define PLD_LOW_PIN_RESET   1'h1

// ======================================================================
// Pin input synchroniser depth
// ======================================================================
`define PLD_SYNC_STAGES     2

`endif

// ---- product_term.v ----
// One AND-array product term over a vector of literals
`timescale 1ns/1ns
`default_nettype none

module product_term #(
    parameter NUM_LITS = 60
) (
    // Literal inputs, true and complement forms
    input  wire [NUM_LITS-1:0] lits_i,
    // Connection map, one bit per literal, 1 means connected
    input  wire [NUM_LITS-1:0] fuse_i,
    // Term result
    output wire                term_o
);

    // ==================================================================
    // AND of every connected literal
    // ==================================================================
    // A term with nothing connected reads true, so an unused control
    // term must be given a contradicting pair to keep it inactive
    assign term_o = &(lits_i | ~fuse_i);

endmodule // product_term

`default_nettype wire

// ---- pld_output_cells.v ----
// Ten output logic macrocells with clock, reset, preset and enable terms
`timescale 1ns/1ns
`default_nettype none
`include "pld_cells_map.vh"

module pld_output_cells #(
    parameter NUM_CELLS = `PLD_NUM_CELLS,
    parameter NUM_DED   = `PLD_NUM_DEDICATED,
    parameter NUM_TERMS = `PLD_TERMS_PER_CELL,
    parameter NUM_LITS  = `PLD_NUM_LITERALS
) (
    // Clock and reset
    input  wire                              sys_clk_i,
    input  wire                              reset_i,
    // Dedicated input pins
    input  wire [NUM_DED-1:0]                ded_in_i,
    // I/O pins, one per cell
    input  wire [NUM_CELLS-1:0]              io_in_i,
    output wire [NUM_CELLS-1:0]              io_out_o,
    output wire [NUM_CELLS-1:0]              io_oe_o,
    // Common enable and preload pins, active low
    input  wire                              out_en_n_i,
    input  wire                              preload_n_i,
    // Static configuration: AND array map and polarity bits
    input  wire [NUM_CELLS*NUM_TERMS*NUM_LITS-1:0] fuse_map_i,
    input  wire [NUM_CELLS-1:0]              polarity_i,
    // Observation of the flip-flops and bypass state
    output wire [NUM_CELLS-1:0]              cell_state_o,
    output wire [NUM_CELLS-1:0]              bypass_o
);

    // ==================================================================
    // Declarations
    // ==================================================================
    // Synchroniser stages for the pins
    reg  [NUM_DED-1:0]   ded_meta_q;
    reg  [NUM_DED-1:0]   ded_sync_q;
    reg  [NUM_CELLS-1:0] io_meta_q;
    reg  [NUM_CELLS-1:0] io_sync_q;
    reg                  out_en_n_meta_q;
    reg                  out_en_n_sync_q;
    reg                  preload_n_meta_q;
    reg                  preload_n_sync_q;

    // Cell storage and edge history
    reg  [NUM_CELLS-1:0] state_q;
    wire [NUM_CELLS-1:0] state_d;
    reg  [NUM_CELLS-1:0] clk_prev_q;
    wire [NUM_CELLS-1:0] clk_prev_d;

    // Registered pin drive
    reg  [NUM_CELLS-1:0] pin_q;
    wire [NUM_CELLS-1:0] pin_d;
    reg  [NUM_CELLS-1:0] oe_q;
    wire [NUM_CELLS-1:0] oe_d;
    reg  [NUM_CELLS-1:0] bypass_q;
    wire [NUM_CELLS-1:0] bypass_d;

    // Array inputs
    wire [`PLD_NUM_SIGNALS-1:0] signals_w;
    wire [NUM_LITS-1:0]         lits_w;
    wire                        preload_w;
    wire                        pin_en_w;

    // ==================================================================
    // Pin synchronisers
    // ==================================================================
    // Two stages for every pin; only the second stage feeds the array
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            ded_meta_q       <= {NUM_DED{1'b0}};
            ded_sync_q       <= {NUM_DED{1'b0}};
            io_meta_q        <= {NUM_CELLS{1'b0}};
            io_sync_q        <= {NUM_CELLS{1'b0}};
            out_en_n_meta_q  <= `PLD_LOW_PIN_RESET;
            out_en_n_sync_q  <= `PLD_LOW_PIN_RESET;
            preload_n_meta_q <= `PLD_LOW_PIN_RESET;
            preload_n_sync_q <= `PLD_LOW_PIN_RESET;
        end else begin
            ded_meta_q       <= ded_in_i;
            ded_sync_q       <= ded_meta_q;
            io_meta_q        <= io_in_i;
            io_sync_q        <= io_meta_q;
            out_en_n_meta_q  <= out_en_n_i;
            out_en_n_sync_q  <= out_en_n_meta_q;
            preload_n_meta_q <= preload_n_i;
            preload_n_sync_q <= preload_n_meta_q;
        end
    end

    // ==================================================================
    // Literal vector for the AND array
    // ==================================================================
    // pins feed array
    // Dedicated inputs and I/O pin levels each have their own column
    assign signals_w[`PLD_SIG_DED_LO +: NUM_DED]  = ded_sync_q;
    assign signals_w[`PLD_SIG_IO_LO  +: NUM_CELLS] = io_sync_q;
    // feedback into array
    // Flip-flop feedback lets any term, clock terms included, use cells
    assign signals_w[`PLD_SIG_FB_LO  +: NUM_CELLS] = state_q;
    // True forms low, complements high
    assign lits_w = {~signals_w, signals_w};

    // Common controls from the pins
    assign preload_w = ~preload_n_sync_q;
    assign pin_en_w  = ~out_en_n_sync_q;

    // ==================================================================
    // Per-cell logic
    // ==================================================================
    genvar c;
    genvar t;
    generate
        for (c = 0; c < NUM_CELLS; c = c + 1) begin : g_cell
            wire [NUM_TERMS-1:0] term_w;
            wire                 sum_w;
            wire                 xor_w;
            wire                 rst_w;
            wire                 pre_w;
            wire                 clk_term_w;
            wire                 clk_rise_w;
            wire                 drive_w;
            wire                 comb_w;
            wire                 reg_next_w;

            // One product term per control and data slot
            for (t = 0; t < NUM_TERMS; t = t + 1) begin : g_term
                product_term #(
                    .NUM_LITS (NUM_LITS)
                ) u_term (
                    .lits_i (lits_w),
                    .fuse_i (fuse_map_i[(c*NUM_TERMS+t)*NUM_LITS +:
                                        NUM_LITS]),
                    .term_o (term_w[t])
                );
            end

            // sum and polarity
            // OR of the data terms, inverted when the polarity bit is set
            assign sum_w = |term_w[`PLD_TERM_DATA_HI:`PLD_TERM_DATA_LO];
            // pin polarity
            // The pin buffer inverts, so bit one makes the pin follow sum
            assign xor_w = sum_w ^ polarity_i[c];

            // Control terms of this cell
            assign rst_w      = term_w[`PLD_TERM_RESET];
            assign pre_w      = term_w[`PLD_TERM_PRESET];
            assign clk_term_w = term_w[`PLD_TERM_CLOCK];

            // own clock edge
            // Edge seen against last cycle's clock term value
            assign clk_rise_w = clk_term_w & ~clk_prev_q[c];
            // History always tracks, so a rise while held is not replayed
            assign clk_prev_d[c] = clk_term_w;

            // enable gating
            // Per-cell term ANDed with the common active-low pin
            assign drive_w = term_w[`PLD_TERM_ENABLE] & pin_en_w;

            // both terms bypass
            // Preload overrides, so bypass is only outside preload
            assign comb_w = ~preload_w & rst_w & pre_w;

            // polarity on clock only
            // Reset and preset load constants; only a clock takes xor_w
            assign reg_next_w = (rst_w & pre_w) ? state_q[c] :
                                rst_w           ? 1'b0       :
                                pre_w           ? 1'b1       :
                                clk_rise_w      ? xor_w      :
                                                  state_q[c];

            // enabled cell keeps state
            // A driven pin would read back its own value, so it holds
            assign state_d[c] = preload_w ?
                                (drive_w ? state_q[c] : ~io_sync_q[c]) :
                                reg_next_w;

            // Pin level: inverting buffer after flip-flop or bypass node
            assign pin_d[c]    = comb_w ? ~xor_w : ~state_d[c];
            assign oe_d[c]     = drive_w;
            assign bypass_d[c] = comb_w;
        end
    endgenerate

    // ==================================================================
    // Cell flip-flops and edge history
    // ==================================================================
    // defined reset state
    // Reset clears every cell, so all pins would read high if enabled.
    // The clock history keeps tracking through reset: a term that is
    // already true when reset ends must not count as a rising edge.
    always @(posedge sys_clk_i) begin
        clk_prev_q <= clk_prev_d;
        if (reset_i) begin
            state_q <= `PLD_STATE_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ==================================================================
    // Registered pin drive and observation
    // ==================================================================
    // Registering the pins costs a cycle but keeps outputs glitch free
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            pin_q    <= `PLD_PIN_RESET;
            oe_q     <= `PLD_ENABLE_RESET;
            bypass_q <= {NUM_CELLS{1'b0}};
        end else begin
            pin_q    <= pin_d;
            oe_q     <= oe_d;
            bypass_q <= bypass_d;
        end
    end

    // Outputs straight from the flip-flops
    assign io_out_o     = pin_q;
    assign io_oe_o      = oe_q;
    assign cell_state_o = state_q;
    assign bypass_o     = bypass_q;

endmodule // pld_output_cells

`default_nettype wire

// ---- cells_sva.sv ----
// Port checker for the output macrocell array
`timescale 1ns/1ns
`default_nettype none
module cells_sva #(
    parameter NUM_CELLS = 10
) (
    // Clock and reset
    input wire logic                 sys_clk_i,
    input wire logic                 reset_i,
    // Pins and observation
    input wire logic [NUM_CELLS-1:0] io_in_i,
    input wire logic [NUM_CELLS-1:0] io_out_o,
    input wire logic [NUM_CELLS-1:0] io_oe_o,
    input wire logic                 out_en_n_i,
    input wire logic                 preload_n_i,
    input wire logic [NUM_CELLS-1:0] cell_state_o,
    input wire logic [NUM_CELLS-1:0] bypass_o
);
    // ======
    // Assertions; six samples cover the sync and output stages
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    reset_state_a: assert property (disable iff (1'b0)
        reset_i |=> !cell_state_o && &io_out_o && !io_oe_o && !bypass_o)
        else $error("reset values wrong");
    oe_off_a: assert property (out_en_n_i [*6] |-> !io_oe_o)
        else $error("output driven while common enable high");
    pin_inv_a: assert property (
        !(~bypass_o & (io_out_o ^ ~cell_state_o)))
        else $error("pin not inverse of state");
    byp_hold_a: assert property (
        !(bypass_o & $past(bypass_o) & (cell_state_o ^ $past(cell_state_o))))
        else $error("state moved during bypass");
    pre_state_a: assert property (
        (!preload_n_i && out_en_n_i && $stable(io_in_i)) [*6]
        |-> cell_state_o == ~io_in_i) else $error("preload state wrong");
    pre_pin_a: assert property (
        (!preload_n_i && out_en_n_i && $stable(io_in_i)) [*6]
        |-> io_out_o == io_in_i) else $error("preload pin wrong");
    pre_keep_a: assert property ((!preload_n_i) [*6] |->
        !((cell_state_o ^ $past(cell_state_o)) & io_oe_o))
        else $error("enabled cell changed in preload");
    pre_nobyp_a: assert property ((!preload_n_i) [*6] |-> !bypass_o)
        else $error("bypass during preload");
endmodule // cells_sva
bind pld_output_cells cells_sva #(.NUM_CELLS(NUM_CELLS)) u_sva (
    .sys_clk_i, .reset_i, .io_in_i, .io_out_o, .io_oe_o, .out_en_n_i,
    .preload_n_i, .cell_state_o, .bypass_o);
`default_nettype wire

// ---- board_pins.sv ----
// Board model resolving the ten I/O pin wires
`timescale 1ns/1ns
`default_nettype none
module board_pins (
    // Device side of each pin
    input  wire logic [9:0] dev_out_i,
    input  wire logic [9:0] dev_oe_i,
    // Board drive and resolved pins
    input  wire logic [9:0] drv_val_i,
    input  wire logic       drv_en_i,
    output var  logic [9:0] pin_o
);
    // pull-up when nobody drives; contention shows as x
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            if (dev_oe_i[i] && drv_en_i) pin_o[i] = 1'bx;
            else if (dev_oe_i[i]) pin_o[i] = dev_out_i[i];
            else if (drv_en_i) pin_o[i] = drv_val_i[i];
            else pin_o[i] = 1'b1;
        end
    end
endmodule // board_pins
`default_nettype wire

// ---- tb_top.sv ----
// Testbench for the output macrocell array
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    // ======
    // Pins; even cells active high
    logic          sys_clk_i = 1'b0;
    logic          reset_i = 1'b1;
    logic [9:0]    ded_in_i = 10'h0;
    logic          out_en_n_i = 1'b1;
    logic          preload_n_i = 1'b1;
    logic [9:0]    drv_val = 10'h0;
    logic          drv_en = 1'b0;
    logic [9:0]    io_pin, io_out_o, io_oe_o, cell_state_o, bypass_o;
    logic [4799:0] fuse_map;
    logic [9:0]    pol_cfg = 10'h155;
    int            miscompares = 0;
    int            samples_checked = 0;
    always #20 sys_clk_i = ~sys_clk_i;
    pld_output_cells uut (
        .sys_clk_i, .reset_i, .ded_in_i, .io_in_i(io_pin), .io_out_o,
        .io_oe_o, .out_en_n_i, .preload_n_i, .fuse_map_i(fuse_map),
        .polarity_i(pol_cfg), .cell_state_o, .bypass_o);
    board_pins board (.dev_out_i(io_out_o), .dev_oe_i(io_oe_o),
        .drv_val_i(drv_val), .drv_en_i(drv_en), .pin_o(io_pin));
    // Each cell: data ded0, clock ded1, reset ded2, preset ded3, enable
    // ded4; data terms 1..3 held false by a literal and its complement
    initial begin
        fuse_map = '0;
        for (int c = 0; c < 10; c++) begin
            fuse_map[c*480] = 1'b1;
            for (int t = 1; t < 4; t++) begin
                fuse_map[c*480+t*60] = 1'b1;
                fuse_map[c*480+t*60+30] = 1'b1;
            end
            for (int t = 4; t < 8; t++) fuse_map[c*480+t*60+t-3] = 1'b1;
        end
    end
    task automatic cmp(input string what, input logic [9:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check(input logic [9:0] st, pin, oe, byp);
        cmp("cell_state_o", st, cell_state_o);
        cmp("io_out_o", pin, io_out_o);
        cmp("io_oe_o", oe, io_oe_o);
        cmp("bypass_o", byp, bypass_o);
    endtask
    // Pins change at an edge; wait out sync and output stages
    task automatic step(input logic [9:0] d, input logic oen, pln);
        @(posedge sys_clk_i);
        ded_in_i <= d;
        out_en_n_i <= oen;
        preload_n_i <= pln;
        repeat (6) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic drive(input logic [9:0] v, input logic en);
        @(posedge sys_clk_i);
        drv_val <= v;
        drv_en <= en;
    endtask
    task automatic results;
        $display("checked %0d, mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Watchdog, far beyond the 196 cycles the sequence needs
    initial begin
        repeat (3000) @(posedge sys_clk_i);
        miscompares++;
        results;
    end
    initial begin
        repeat (20) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        #1;
        check(10'h0, 10'h3ff, 10'h0, 10'h0);
        step(10'h001, 1, 1);
        step(10'h003, 1, 1);
        check(~pol_cfg, pol_cfg, 10'h0, 10'h0);
        step(10'h000, 1, 1);
        step(10'h002, 1, 1);
        check(pol_cfg, ~pol_cfg, 10'h0, 10'h0);
        step(10'h012, 0, 1);
        check(pol_cfg, ~pol_cfg, 10'h3ff, 10'h0);
        step(10'h002, 0, 1);
        check(pol_cfg, ~pol_cfg, 10'h0, 10'h0);
        step(10'h006, 1, 1);
        check(10'h0, 10'h3ff, 10'h0, 10'h0);
        step(10'h005, 1, 1);
        step(10'h007, 1, 1);
        check(10'h0, 10'h3ff, 10'h0, 10'h0);
        step(10'h009, 1, 1);
        step(10'h00b, 1, 1);
        check(10'h3ff, 10'h0, 10'h0, 10'h0);
        step(10'h00c, 1, 1);
        check(10'h3ff, ~pol_cfg, 10'h0, 10'h3ff);
        step(10'h00d, 1, 1);
        check(10'h3ff, pol_cfg, 10'h0, 10'h3ff);
        step(10'h000, 1, 1);
        check(10'h3ff, 10'h0, 10'h0, 10'h0);
        drive(10'h2a5, 1);
        step(10'h000, 1, 0);
        check(10'h15a, 10'h2a5, 10'h0, 10'h0);
        step(10'h002, 1, 0);
        check(10'h15a, 10'h2a5, 10'h0, 10'h0);
        step(10'h000, 1, 1);
        drive(10'h0, 0);
        step(10'h010, 0, 1);
        check(10'h15a, 10'h2a5, 10'h3ff, 10'h0);
        // Board fights the driven pins, so a reload from them would show
        drive(10'h000, 1);
        step(10'h010, 0, 0);
        check(10'h15a, 10'h2a5, 10'h3ff, 10'h0);
        drive(10'h0, 0);
        step(10'h000, 1, 1);
        // Cell 9 clocked by the inverse of cell 8's flip-flop, not ded1
        @(posedge sys_clk_i);
        fuse_map[4561] <= 1'b0;
        fuse_map[4618] <= 1'b1;
        step(10'h001, 1, 1);
        step(10'h003, 1, 1);
        check(~pol_cfg, pol_cfg, 10'h0, 10'h0);
        step(10'h000, 1, 1);
        step(10'h002, 1, 1);
        check(10'h355, 10'h0aa, 10'h0, 10'h0);
        // Reset again in mid-run, from a non-zero state
        @(posedge sys_clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        #1;
        check(10'h0, 10'h3ff, 10'h0, 10'h0);
        results;
    end
endmodule // tb_top
`default_nettype wire
